/* shared/fsled_pkg.sv */
// fsled_pkg: constants, register layouts and enumerations of the status led driver.
// assumes a single 100 MHz system clock and a 32-bit ahb-lite register bus.
package fsled_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned FLASH_ON_MS = 200;
  localparam int unsigned FLASH_GAP_MS = 200;
  localparam int unsigned LONG_OFF_MS = 1000;
  localparam int unsigned FLICKER_MS = 50;
  localparam real PREOP_BLINK_HZ = 2.5;
  localparam real LDR_IDLE_HZ = 1.0;
  localparam real LDR_BUSY_HZ = 6.0;
  localparam real CFG_BLINK_HZ = 2.5;

  // times round down to whole cycles, never below one cycle
  function automatic int unsigned ms_to_cyc(input int unsigned ms);
    int unsigned c;
    c = CYC_PER_MS * ms;
    return (c == 0) ? 1 : c;
  endfunction

  function automatic int unsigned hz_to_half_cyc(input real hz);
    int unsigned c;
    c = $rtoi(real'(CLK_HZ) / (2.0 * hz));
    return (c == 0) ? 1 : c;
  endfunction

  localparam int unsigned FLASH_ON_CYC = ms_to_cyc(FLASH_ON_MS);
  localparam int unsigned FLASH_GAP_CYC = ms_to_cyc(FLASH_GAP_MS);
  localparam int unsigned LONG_OFF_CYC = ms_to_cyc(LONG_OFF_MS);
  localparam int unsigned FLICKER_CYC = ms_to_cyc(FLICKER_MS);
  localparam int unsigned PREOP_HALF_CYC = hz_to_half_cyc(PREOP_BLINK_HZ);
  localparam int unsigned LDR_IDLE_HALF_CYC = hz_to_half_cyc(LDR_IDLE_HZ);
  localparam int unsigned LDR_BUSY_HALF_CYC = hz_to_half_cyc(LDR_BUSY_HZ);
  localparam int unsigned CFG_HALF_CYC = hz_to_half_cyc(CFG_BLINK_HZ);
  localparam int unsigned PAT_CNT_W = 27;

  // ==========================================================================
  // enumerations
  // ==========================================================================
  typedef enum logic [2:0] {
    pat_off, pat_on, pat_blink_preop, pat_blink_idle, pat_blink_busy, pat_flicker, pat_single, pat_double
  } fsled_pat_t;

  typedef enum logic [1:0] {al_init, al_preop, al_safeop, al_op} fsled_al_t;

  typedef enum logic [1:0] {ldr_off, ldr_idle, ldr_busy, ldr_rsvd} fsled_ldr_t;

  // ==========================================================================
  // register bus
  // ==========================================================================
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ERR_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FATAL_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STAT_OFS = 8'h0c;
  localparam logic [1:0] WORD_ALIGN = 2'h0;
  localparam logic HRESP_OKAY = 1'h0;
  localparam logic [7:0] AL_CHANGE_CODE = 8'h01;
  localparam logic [15:0] FATAL_OBJ_INDEX = 16'h4000;
  localparam logic [15:0] FATAL_NONE = 16'h0000;

  typedef struct packed {
    logic [26:0] rsvd;
    fsled_ldr_t ldr;
    logic started;
    fsled_al_t al;
  } fsled_ctrl_reg_t;

  typedef struct packed {
    logic [20:0] rsvd;
    logic cfg_err;
    logic pdi_fail;
    logic wdog;
    logic [7:0] change;
  } fsled_err_reg_t;

  typedef struct packed {
    logic [15:0] obj;
    logic [15:0] cause;
  } fsled_fatal_reg_t;

  typedef struct packed {
    logic [21:0] rsvd;
    logic fatal;
    logic [1:0] traffic;
    logic [1:0] link;
    logic err_led;
    logic run_red;
    logic run_green;
    logic [1:0] la_led;
  } fsled_stat_reg_t;

endpackage

/* rtl/fsled_pattern.sv */
// fsled_pattern: one led pattern generator with two colour outputs.
// assumes the selected pattern and hue come from logic on the same clock.
`timescale 1ns/1ps
module fsled_pattern import fsled_pkg::*; #(
  parameter int unsigned CNT_W = PAT_CNT_W,
  parameter int unsigned FLASH_CYC = FLASH_ON_CYC,
  parameter int unsigned GAP_CYC = FLASH_GAP_CYC,
  parameter int unsigned LONG_CYC = LONG_OFF_CYC,
  parameter int unsigned FLICK_CYC = FLICKER_CYC,
  parameter int unsigned PREOP_CYC = PREOP_HALF_CYC,
  parameter int unsigned IDLE_CYC = LDR_IDLE_HALF_CYC,
  parameter int unsigned BUSY_CYC = LDR_BUSY_HALF_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // pattern request
  input wire fsled_pat_t pat_sel,
  input wire logic hue,
  // led drive: a when hue low, b when hue high
  output logic led_a,
  output logic led_b
);

  typedef struct packed {
    logic lit;
    logic last;
    logic [CNT_W-1:0] len;
  } fsled_phase_t;

  typedef struct packed {
    fsled_pat_t pat;
    logic hue;
    logic [1:0] phase;
    logic [CNT_W-1:0] cnt;
    logic led_a;
    logic led_b;
  } fsled_pst_t;

  fsled_pst_t q, d;

  // ==========================================================================
  // phase table
  // ==========================================================================
  function automatic fsled_phase_t phase_info(input fsled_pat_t p, input logic [1:0] ph);
    fsled_phase_t r;
    r = '{lit: 1'b0, last: 1'b1, len: CNT_W'(1)};
    unique case (p)
      pat_off: r.lit = 1'b0;
      pat_on: r.lit = 1'b1;
      pat_blink_preop: r = '{lit: ~ph[0], last: ph[0], len: CNT_W'(PREOP_CYC)};
      pat_blink_idle: r = '{lit: ~ph[0], last: ph[0], len: CNT_W'(IDLE_CYC)};
      pat_blink_busy: r = '{lit: ~ph[0], last: ph[0], len: CNT_W'(BUSY_CYC)};
      pat_flicker: r = '{lit: ~ph[0], last: ph[0], len: CNT_W'(FLICK_CYC)};
      pat_single: r = '{lit: ~ph[0], last: ph[0], len: ph[0] ? CNT_W'(LONG_CYC) : CNT_W'(FLASH_CYC)};
      pat_double: begin
        r.lit = ~ph[0];
        r.last = (ph == 2'h3);
        r.len = (ph == 2'h3) ? CNT_W'(LONG_CYC) : (ph == 2'h1) ? CNT_W'(GAP_CYC) : CNT_W'(FLASH_CYC);
      end
    endcase
    return r;
  endfunction

  // ==========================================================================
  // sequencer
  // ==========================================================================
  always_comb begin
    fsled_phase_t cur;
    fsled_phase_t nxt;
    d = q;
    cur = phase_info(q.pat, q.phase);
    if (pat_sel != q.pat || hue != q.hue) begin
      d.pat = pat_sel;
      d.hue = hue;
      d.phase = 2'h0;
      d.cnt = '0;
    end else if (q.cnt >= cur.len - CNT_W'(1)) begin
      d.cnt = '0;
      d.phase = cur.last ? 2'h0 : q.phase + 2'h1;
    end else begin
      d.cnt = q.cnt + CNT_W'(1);
    end
    nxt = phase_info(d.pat, d.phase);
    d.led_a = nxt.lit & ~d.hue;
    d.led_b = nxt.lit & d.hue;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      q <= '{pat: pat_off, hue: 1'b0, phase: 2'h0, cnt: '0, led_a: 1'b0, led_b: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign led_a = q.led_a;
  assign led_b = q.led_b;

endmodule // fsled_pattern

/* rtl/fsled_top.sv */
// fsled_top: status indicator logic of a fieldbus slave card, with ahb-lite registers.
// assumes link and traffic pins are asynchronous; the bus runs on sys_clk; one slave.
//
// Contract
// - link/activity led off without physical link or before controller start
// - link/activity led steady green with link but no frame traffic
// - link/activity led flickers green while frames move on the port
// - run led dark in the init state
// - run led blinks green at about 2.5 Hz in pre-operational
// - run led single green flash, 200 ms on, 1000 ms off, in safe-operational
// - run led steady green in operational
// - firmware loader blinks run led red, 1 Hz idle, 6 Hz busy
// - error led off when nothing is wrong
// - status change code 0x01 gives red single flash, 200 ms on, 1000 ms off
// - watchdog timeout gives red double flash, 200/200/200 ms, then 1000 ms off
// - error led steady red when the process data interface failed
// - fatal event lights error led steadily and records its cause
// - firmware loader also blinks error led red, 1 Hz idle, 6 Hz busy
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module fsled_top import fsled_pkg::*; #(
  parameter int unsigned CNT_W = PAT_CNT_W,
  parameter int unsigned FLASH_CYC = FLASH_ON_CYC,
  parameter int unsigned GAP_CYC = FLASH_GAP_CYC,
  parameter int unsigned LONG_CYC = LONG_OFF_CYC,
  parameter int unsigned FLICK_CYC = FLICKER_CYC,
  parameter int unsigned PREOP_CYC = PREOP_HALF_CYC,
  parameter int unsigned IDLE_CYC = LDR_IDLE_HALF_CYC,
  parameter int unsigned BUSY_CYC = LDR_BUSY_HALF_CYC,
  parameter int unsigned CFG_CYC = CFG_HALF_CYC,
  parameter int unsigned NPORT = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // physical port state, asynchronous
  input wire logic [NPORT-1:0] link_up,
  input wire logic [NPORT-1:0] traffic,
  // status leds
  output logic [NPORT-1:0] la_led,
  output logic run_green,
  output logic run_red,
  output logic err_led
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [NPORT-1:0] link_s1;
    logic [NPORT-1:0] link_s2;
    logic [NPORT-1:0] trf_s1;
    logic [NPORT-1:0] trf_s2;
    fsled_ctrl_reg_t ctrl;
    fsled_err_reg_t err;
    logic fatal;
    logic [15:0] fatal_cause;
    logic dp_wr;
    logic [ADDR_W-1:0] dp_addr;
    logic [31:0] rdata;
  } fsled_state_t;

  fsled_state_t q, d;

  fsled_pat_t la_pat [NPORT];
  fsled_pat_t run_pat;
  fsled_pat_t err_pat;
  logic run_hue;
  logic err_lit;
  logic [NPORT-1:0] la_lit;

  // ==========================================================================
  // pattern selection
  // ==========================================================================
  function automatic fsled_pat_t link_pattern(input logic started, input logic link, input logic busy);
    fsled_pat_t p;
    if (!started || !link) begin
      p = pat_off;
    end else if (busy) begin
      p = pat_flicker;
    end else begin
      p = pat_on;
    end
    return p;
  endfunction

  function automatic fsled_pat_t loader_pattern(input fsled_ldr_t m);
    return (m == ldr_idle) ? pat_blink_idle : pat_blink_busy;
  endfunction

  function automatic logic loader_active(input fsled_ldr_t m);
    return m != ldr_off;
  endfunction

  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      la_pat[i] = link_pattern(q.ctrl.started, q.link_s2[i], q.trf_s2[i]);
    end
  end

  // run led: loader owns it in red, otherwise it follows the slave state in green
  always_comb begin
    run_hue = 1'b0;
    if (loader_active(q.ctrl.ldr)) begin
      run_pat = loader_pattern(q.ctrl.ldr);
      run_hue = 1'b1;
    end else begin
      unique case (q.ctrl.al)
        al_init: run_pat = pat_off;
        al_preop: run_pat = pat_blink_preop;
        al_safeop: run_pat = pat_single;
        al_op: run_pat = pat_on;
      endcase
    end
  end

  // error led: the most severe present condition decides
  always_comb begin
    if (q.err.pdi_fail) begin
      err_pat = pat_on;
    end else if (q.fatal) begin
      err_pat = pat_on;
    end else if (q.err.wdog) begin
      err_pat = pat_double;
    end else if (q.err.change == AL_CHANGE_CODE) begin
      err_pat = pat_single;
    end else if (loader_active(q.ctrl.ldr)) begin
      err_pat = loader_pattern(q.ctrl.ldr);
    end else if (q.err.cfg_err) begin
      err_pat = pat_blink_preop;
    end else begin
      err_pat = pat_off;
    end
  end

  // ==========================================================================
  // register file and bus
  // ==========================================================================
  function automatic logic [31:0] read_reg(input fsled_state_t s, input logic [ADDR_W-1:0] a,
                                           input fsled_stat_reg_t st);
    fsled_fatal_reg_t f;
    logic [31:0] r;
    f = '{obj: FATAL_OBJ_INDEX, cause: s.fatal_cause};
    unique case (a)
      REG_CTRL_OFS: r = s.ctrl;
      REG_ERR_OFS: r = s.err;
      REG_FATAL_OFS: r = f;
      REG_STAT_OFS: r = st;
      default: r = '0;
    endcase
    return r;
  endfunction

  always_comb begin
    fsled_stat_reg_t st;
    fsled_fatal_reg_t wf;
    logic take;
    d = q;
    st = '0;
    wf = hwdata;
    take = 1'b0;
    // two-stage synchronisers on the port pins
    d.link_s1 = link_up;
    d.link_s2 = q.link_s1;
    d.trf_s1 = traffic;
    d.trf_s2 = q.trf_s1;
    // data phase of a write
    if (q.dp_wr) begin
      unique case (q.dp_addr)
        REG_CTRL_OFS: begin
          d.ctrl = hwdata;
          d.ctrl.rsvd = '0;
        end
        REG_ERR_OFS: begin
          d.err = hwdata;
          d.err.rsvd = '0;
        end
        REG_FATAL_OFS: begin
          if (!q.fatal && wf.cause != FATAL_NONE) begin
            d.fatal = 1'b1;
            d.fatal_cause = wf.cause;
          end
        end
        default: ;
      endcase
    end
    // address phase: latch writes, read from the updated copy
    take = hsel && hready && htrans[1];
    d.dp_wr = take && hwrite && (haddr[1:0] == WORD_ALIGN);
    d.dp_addr = haddr;
    st.fatal = q.fatal;
    st.traffic = q.trf_s2;
    st.link = q.link_s2;
    st.err_led = err_lit;
    st.run_red = run_red;
    st.run_green = run_green;
    st.la_led = la_lit;
    if (take && !hwrite) begin
      d.rdata = read_reg(d, haddr, st);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = q.rdata;

  // ==========================================================================
  // led generators
  // ==========================================================================
  for (genvar i = 0; i < NPORT; i++) begin : g_la
    fsled_pattern #(
      .CNT_W(CNT_W), .FLASH_CYC(FLASH_CYC), .GAP_CYC(GAP_CYC), .LONG_CYC(LONG_CYC),
      .FLICK_CYC(FLICK_CYC), .PREOP_CYC(PREOP_CYC), .IDLE_CYC(IDLE_CYC), .BUSY_CYC(BUSY_CYC)
    ) u_la (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .pat_sel(la_pat[i]),
      .hue(1'b0),
      .led_a(la_lit[i]),
      .led_b()
    );
  end

  fsled_pattern #(
    .CNT_W(CNT_W), .FLASH_CYC(FLASH_CYC), .GAP_CYC(GAP_CYC), .LONG_CYC(LONG_CYC),
    .FLICK_CYC(FLICK_CYC), .PREOP_CYC(PREOP_CYC), .IDLE_CYC(IDLE_CYC), .BUSY_CYC(BUSY_CYC)
  ) u_run (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pat_sel(run_pat),
    .hue(run_hue),
    .led_a(run_green),
    .led_b(run_red)
  );

  // the error led reuses the pre-operational slot, timed by CFG_CYC, for its even blink
  fsled_pattern #(
    .CNT_W(CNT_W), .FLASH_CYC(FLASH_CYC), .GAP_CYC(GAP_CYC), .LONG_CYC(LONG_CYC),
    .FLICK_CYC(FLICK_CYC), .PREOP_CYC(CFG_CYC), .IDLE_CYC(IDLE_CYC), .BUSY_CYC(BUSY_CYC)
  ) u_err (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pat_sel(err_pat),
    .hue(1'b0),
    .led_a(err_lit),
    .led_b()
  );

  assign la_led = la_lit;
  assign err_led = err_lit;

endmodule // fsled_top

/* sim/fsled_top_monitor.sv */
// fsled_top_monitor: port-level assertions on the status led driver.
// assumes it is bound into fsled_top; one clock, synchronous reset.
`timescale 1ns/1ps
module fsled_top_monitor import fsled_pkg::*; #(
  parameter int unsigned FLICK_CYC = FLICKER_CYC,
  parameter int unsigned NPORT = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // pins and leds
  input wire logic [NPORT-1:0] link_up,
  input wire logic [NPORT-1:0] traffic,
  input wire logic [NPORT-1:0] la_led,
  input wire logic run_green,
  input wire logic run_red,
  input wire logic err_led
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ==========
  // port 0 helper counters
  logic [3:0] scnt_q;
  logic [3:0] tcnt_q;
  int unsigned hold_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      scnt_q <= 4'h0;
      tcnt_q <= 4'h0;
      hold_q <= 0;
    end else begin
      scnt_q <= (link_up[0] && !traffic[0]) ? scnt_q + {3'h0, scnt_q != 4'hf} : 4'h0;
      tcnt_q <= (link_up[0] && traffic[0]) ? tcnt_q + {3'h0, tcnt_q != 4'hf} : 4'h0;
      hold_q <= $stable(la_led[0]) ? hold_q + 1 : 0;
    end
  end
  // ==========
  // properties
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; hresp == HRESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_rst_off; $rose(rstn) |-> !run_green && !run_red && !err_led && la_led == '0; endproperty
  a_rst_off: assert property (p_rst_off) else $error("led lit out of reset");
  property p_bicolour; !(run_green && run_red); endproperty
  a_bicolour: assert property (p_bicolour) else $error("run led both colours");
  property p_nolink0; !link_up[0] [*5] |-> !la_led[0]; endproperty
  a_nolink0: assert property (p_nolink0) else $error("port 0 lit without link");
  property p_nolink1; !link_up[1] [*5] |-> !la_led[1]; endproperty
  a_nolink1: assert property (p_nolink1) else $error("port 1 lit without link");
  property p_steady; scnt_q >= 4'h6 && $past(la_led[0]) |-> la_led[0]; endproperty
  a_steady: assert property (p_steady) else $error("port 0 not steady");
  property p_flick; tcnt_q >= 4'h8 |-> hold_q < FLICK_CYC; endproperty
  a_flick: assert property (p_flick) else $error("port 0 not flickering");
  c_flick: cover property (tcnt_q >= 4'h8);
  c_red: cover property (run_red);
  c_err: cover property (err_led);
endmodule // fsled_top_monitor

bind fsled_top fsled_top_monitor #(.FLICK_CYC(FLICK_CYC), .NPORT(NPORT)) fsled_top_monitor_inst (
  .sys_clk(sys_clk), .rstn(rstn), .hreadyout(hreadyout), .hresp(hresp), .link_up(link_up),
  .traffic(traffic), .la_led(la_led), .run_green(run_green), .run_red(run_red), .err_led(err_led));

/* sim/fsled_led_observer.sv */
// fsled_led_observer: operator's eye on one led, counting lit-ups.
// assumes the led is sampled on sys_clk; clr restarts the count.
`timescale 1ns/1ps
module fsled_led_observer (
  // clock and control
  input wire logic sys_clk,
  input wire logic clr,
  // watched led and count
  input wire logic led,
  output int rises
);
  logic last = 1'b0;
  // ==========
  // count dark-to-lit changes
  always @(posedge sys_clk) begin
    if (clr) begin
      rises <= 0;
    end else if (led && !last) begin
      rises <= rises + 1;
    end
    last <= led;
  end
endmodule // fsled_led_observer

/* sim/fsled_top_tb.sv */
// fsled_top_tb: self-checking bench of the status led driver.
// assumes shortened pattern counts; one slave, hready is hreadyout.
`timescale 1ns/1ps
module fsled_top_tb import fsled_pkg::*;;
  localparam int FL = 4, GP = 3, LG = 10, FK = 2, PR = 3, ID = 5, BZ = 2, CF = 4;
  logic sys_clk = 1'b0, rstn = 1'b0, hsel = 1'b1, hwrite = 1'b0, clr = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0, link_up = 2'h0, traffic = 2'h0, la_led;
  logic [31:0] hwdata = 32'h0, hrdata, rdv;
  logic hreadyout, hresp, run_green, run_red, err_led;
  logic [39:0] on_w, off_w, err_e [7];
  logic [31:0] err_v [7] = '{32'h400, 32'h1, 32'h2, 32'h501, 32'h701, 32'h200, 32'h0};
  int mismatches = 0, checked = 0, rises;
  always #5 sys_clk = ~sys_clk;
  fsled_top #(.FLASH_CYC(FL), .GAP_CYC(GP), .LONG_CYC(LG), .FLICK_CYC(FK), .PREOP_CYC(PR),
    .IDLE_CYC(ID), .BUSY_CYC(BZ), .CFG_CYC(CF)) fsled_top_inst (.sys_clk(sys_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link_up(link_up),
    .traffic(traffic), .la_led(la_led), .run_green(run_green), .run_red(run_red), .err_led(err_led));
  fsled_led_observer fsled_led_observer_inst (.sys_clk(sys_clk), .clr(clr), .led(la_led[0]), .rises(rises));
  // ==========
  // helpers
  task complete_run;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cmp(input string n, input logic [39:0] e, input logic [39:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wait_rdy;
    int i;
    i = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        mismatches++;
        complete_run;
      end
      @(posedge sys_clk);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rdv = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    cmp("read", {8'h0, e}, {8'h0, rdv});
  endtask
  function automatic logic [39:0] mk(input int a, b, c, d);
    int p;
    mk = '0;
    for (int i = 0; i < 40; i++) begin
      p = i % (a + b + c + d);
      mk[i] = (p < a) || (p >= a + b && p < a + b + c);
    end
  endfunction
  // samples 40 cycles from the first cycle of the new pattern
  task wave(input string n, input logic [39:0] eg, input logic [39:0] er, input logic [39:0] ee);
    logic [39:0] g, r, e;
    @(posedge sys_clk);
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      g[i] = run_green;
      r[i] = run_red;
      e[i] = err_led;
    end
    cmp({n, " green"}, eg, g);
    cmp({n, " red"}, er, r);
    cmp({n, " err"}, ee, e);
  endtask
  // ==========
  // scenarios
  task t_run;
    wave("init", off_w, off_w, off_w);
    wr(REG_CTRL_OFS, 32'h1);
    wave("preop", mk(PR, PR, 0, 0), off_w, off_w);
    wr(REG_CTRL_OFS, 32'h2);
    wave("safeop", mk(FL, LG, 0, 0), off_w, off_w);
    wr(REG_CTRL_OFS, 32'hb);
    wave("ldr idle", off_w, mk(ID, ID, 0, 0), mk(ID, ID, 0, 0));
    wr(REG_CTRL_OFS, 32'h13);
    wave("ldr busy", off_w, mk(BZ, BZ, 0, 0), mk(BZ, BZ, 0, 0));
    rd(REG_CTRL_OFS, 32'h13);
    rd(8'h10, 32'h0);
    wr(REG_CTRL_OFS, 32'h3);
    wr(8'h01, 32'h0);
    wave("op", on_w, off_w, off_w);
  endtask
  task t_err;
    err_e = '{mk(CF, CF, 0, 0), mk(FL, LG, 0, 0), off_w, mk(FL, GP, FL, LG), on_w, on_w, off_w};
    foreach (err_v[i]) begin
      wr(REG_ERR_OFS, err_v[i]);
      wave("err", on_w, off_w, err_e[i]);
    end
  endtask
  task t_link;
    link_up <= 2'h3;
    idle(6);
    cmp("la unstarted", 40'h0, {38'h0, la_led});
    wr(REG_CTRL_OFS, 32'h7);
    idle(6);
    cmp("la steady", 40'h3, {38'h0, la_led});
    link_up <= 2'h1;
    traffic <= 2'h1;
    idle(8);
    clr <= 1'b1;
    idle(1);
    clr <= 1'b0;
    idle(21);
    cmp("la flicker", 40'h5, 40'(rises));
    cmp("la1 no link", 40'h0, {39'h0, la_led[1]});
    link_up <= 2'h0;
    traffic <= 2'h0;
    idle(6);
    cmp("la no link", 40'h0, {38'h0, la_led});
  endtask
  task t_fatal;
    wr(REG_FATAL_OFS, 32'h5);
    wave("fatal", on_w, off_w, on_w);
    wr(REG_FATAL_OFS, 32'h9);
    wr(REG_STAT_OFS, 32'hffffffff);
    rd(REG_FATAL_OFS, {FATAL_OBJ_INDEX, 16'h5});
    rd(REG_STAT_OFS, 32'h214);
    rstn <= 1'b0;
    idle(2);
    cmp("reset leds", 40'h0, {35'h0, la_led, run_green, run_red, err_led});
    rstn <= 1'b1;
    wave("after reset", off_w, off_w, off_w);
  endtask
  initial begin
    on_w = mk(1, 0, 0, 0);
    off_w = mk(0, 1, 0, 0);
    idle(2);
    cmp("reset leds", 40'h0, {35'h0, la_led, run_green, run_red, err_led});
    rstn <= 1'b1;
    t_run;
    t_err;
    t_link;
    t_fatal;
    complete_run;
  end
endmodule // fsled_top_tb
